// ### inc/lesr_extended_line_status_if.sv
// Purpose: Carries fault vectors into the extended status encoder
// Assumes: Purely combinational path inside one clock domain
// Notes: Letter faults a..h in bits 0..7, transfer faults 1..6 in 0..5
`timescale 1ns/1ps
interface lesr_ext_if;
	logic [lesr_pkg::LETTERS-1:0] letter_faults;
	logic [lesr_pkg::DMA_CAUSES-1:0] dma_faults;
	logic [7:0] ext_code;
	modport encoder (input letter_faults, input dma_faults, output ext_code);
	modport user (output letter_faults, output dma_faults, input ext_code);
endinterface : lesr_ext_if

// ### inc/lesr_pkg.sv
// Purpose: Shared constants and types of the line error status reporter
// Assumes: Status bytes are MSB-first, documented bit 0 sits in [7]
// Notes: Codes are {initial field, final field, flag}
package lesr_pkg;
	localparam logic [2:0] INIT_INTERNAL = 3'h6;
	localparam logic [2:0] INIT_HARDWARE = 3'h7;
	localparam logic [3:0] FINAL_CLOCK_FAIL = 4'h7;
	localparam logic [3:0] FINAL_EXT_VALID = 4'he;
	localparam logic [3:0] FINAL_NOT_ACCESSIBLE = 4'hf;
	localparam logic [7:0] STATUS_IDLE = 8'h00;
	localparam logic [7:0] STATUS_CLOCK_FAIL = 8'hce;
	localparam logic [7:0] STATUS_EXT_VALID = 8'hdc;
	localparam logic [7:0] STATUS_NOT_ACCESSIBLE = 8'hde;
	// Read/write, bus check, IO tag, halt, address tag, data tag
	localparam logic [7:0] HALT_MASK = 8'hde;
	localparam int LETTERS = 8;
	localparam int DMA_CAUSES = 6;
	localparam int BURST_BIT = 5;
	// Single causes a..h, then 1..6, then fault combinations and the catch-all codes
	localparam logic [7:0] EXT_A = 8'h02;
	localparam logic [7:0] EXT_B = 8'h12;
	localparam logic [7:0] EXT_C = 8'h10;
	localparam logic [7:0] EXT_D = 8'h22;
	localparam logic [7:0] EXT_E = 8'h04;
	localparam logic [7:0] EXT_F = 8'h14;
	localparam logic [7:0] EXT_G = 8'h28;
	localparam logic [7:0] EXT_H = 8'h4a;
	localparam logic [7:0] EXT_1 = 8'h0a;
	localparam logic [7:0] EXT_2 = 8'h1a;
	localparam logic [7:0] EXT_3 = 8'h08;
	localparam logic [7:0] EXT_4 = 8'h18;
	localparam logic [7:0] EXT_5 = 8'h2a;
	localparam logic [7:0] EXT_6 = 8'h3a;
	localparam logic [7:0] EXT_FG = 8'h06;
	localparam logic [7:0] EXT_FH = 8'h16;
	localparam logic [7:0] EXT_EF = 8'h24;
	localparam logic [7:0] EXT_EFG = 8'h34;
	localparam logic [7:0] EXT_2EFG = 8'h44;
	localparam logic [7:0] EXT_1EFG = 8'h5a;
	localparam logic [7:0] EXT_2G = 8'h6a;
	localparam logic [7:0] EXT_2H = 8'h7a;
	localparam logic [7:0] EXT_5EFG = 8'h9a;
	localparam logic [7:0] EXT_BURST_ANY = 8'haa;
	localparam logic [7:0] EXT_OTHER = 8'hba;
	localparam logic [7:0] EXT_NONE = 8'h00;
	typedef enum logic [1:0] {
		LINE_ACTIVE = 2'b00,
		LINE_DISABLED = 2'b01,
		LINE_NOOP = 2'b10
	} lesr_line_t;
	typedef enum logic [2:0] {
		CMD_SET_MODE = 3'b000,
		CMD_ENABLE = 3'b001,
		CMD_MONITOR_CALL = 3'b010,
		CMD_DIAL = 3'b011,
		CMD_OTHER = 3'b100
	} lesr_cmd_t;
endpackage : lesr_pkg

// ### tb/lesr_ccu_model.sv
// Purpose: Controller side that reads pending line status and halt records
// Assumes: Reads are one-cycle pulses issued a set number of cycles late
// Notes: Keeps what it read so the bench can check held values
`timescale 1ns/1ps
module lesr_ctrl_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] read_delay,
	input wire logic level2_irq,
	input wire logic level1_irq,
	input wire logic [7:0] line_comm_status,
	input wire logic [7:0] extended_line_status,
	input wire logic [7:0] halt_error_record_byte0,
	output logic status_read,
	output logic halt_read,
	output logic [7:0] seen_status,
	output logic [7:0] seen_ext,
	output logic [7:0] seen_halt
);
	logic [3:0] wait2_reg;
	logic [3:0] wait1_reg;
	// A late read lets the bench watch the held value first
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			status_read <= 1'b0;
			wait2_reg <= 4'h0;
			seen_status <= 8'h00;
			seen_ext <= 8'h00;
		end else if (level2_irq && !status_read && wait2_reg >= read_delay) begin
			status_read <= 1'b1;
			wait2_reg <= 4'h0;
			seen_status <= line_comm_status;
			seen_ext <= extended_line_status;
		end else begin
			status_read <= 1'b0;
			wait2_reg <= (level2_irq && !status_read) ? wait2_reg + 4'h1 : 4'h0;
		end
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			halt_read <= 1'b0;
			wait1_reg <= 4'h0;
			seen_halt <= 8'h00;
		end else if (level1_irq && !halt_read && wait1_reg >= read_delay) begin
			halt_read <= 1'b1;
			wait1_reg <= 4'h0;
			seen_halt <= halt_error_record_byte0;
		end else begin
			halt_read <= 1'b0;
			wait1_reg <= (level1_irq && !halt_read) ? wait1_reg + 4'h1 : 4'h0;
		end
	end
endmodule : lesr_ctrl_model

// ### tb/tb.sv
// Purpose: Random and corner checks of the line error status reporter
// Assumes: Inputs change 10 ns after the rising edge of mclk
// Notes: Expected codes are rebuilt from the field layout and code lists
`timescale 1ns/1ps
module tb;
	logic mclk, rst_b, high_speed_mode, emulation_mode, duplex_line, autocall_iface;
	logic err_valid, err_hardware, err_flag, err_iface, dma_fault_valid, restr;
	logic [3:0] err_cause, read_delay;
	logic [7:0] letter_faults, ext_reg02, line_comm_status, extended_line_status, code;
	logic [5:0] dma_faults;
	logic attach_clock_fail, local_attach_busy, cmd_valid, cmd_iface, other_line_active;
	logic [2:0] cmd_code;
	logic status_read, halt_signal, prog_op_active, halt_read, level2_irq, level1_irq;
	logic [7:0] halt_error_record_byte0, seen_status, seen_ext, seen_halt;
	logic [1:0] line_state, iface_end, iface_clear;
	logic cmd_accept, cmd_reject;
	int error_cnt, tests_run;
	logic [7:0] fast_tab [19] = '{8'hc0, 8'hc2, 8'hc4, 8'hc6, 8'hc8, 8'hce, 8'hd0, 8'hd2,
		8'hd4, 8'hd8, 8'hdc, 8'hde, 8'he2, 8'hee, 8'hf2, 8'hf4, 8'hf6, 8'hf8, 8'hfa};
	// Letter faults, transfer faults, extended code
	logic [23:0] ext_tab [24] = '{24'h010002, 24'h020012, 24'h040010, 24'h080022,
		24'h100004, 24'h200014, 24'h400028, 24'h80004a, 24'h00010a, 24'h00021a,
		24'h000408, 24'h000818, 24'h00102a, 24'h00203a, 24'h600006, 24'ha00016,
		24'h300024, 24'h700034, 24'h700244, 24'h70015a, 24'h40026a, 24'h80027a,
		24'h70109a, 24'h0101ba};

	lesr_top dut (.mclk, .rst_b, .high_speed_mode, .emulation_mode, .duplex_line,
		.autocall_iface,
		.err_valid, .err_hardware, .err_cause, .err_flag, .err_iface, .dma_fault_valid,
		.letter_faults, .dma_faults, .attach_clock_fail, .local_attach_busy, .cmd_valid,
		.cmd_code, .cmd_iface, .other_line_active, .status_read, .halt_signal, .prog_op_active,
		.ext_reg02, .halt_read, .line_comm_status, .extended_line_status, .level2_irq,
		.level1_irq, .halt_error_record_byte0, .line_state, .iface_end, .iface_clear,
		.cmd_accept, .cmd_reject);
	lesr_ctrl_model ctrl (.mclk, .rst_b, .read_delay, .level2_irq, .level1_irq,
		.line_comm_status, .extended_line_status, .halt_error_record_byte0, .status_read,
		.halt_read, .seen_status, .seen_ext, .seen_halt);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic results;
		if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic chk_bit(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : chk_bit

	task automatic step(input int n = 1);
		repeat (n) @(posedge mclk);
		#10;
	endtask : step

	// Bounded wait for the controller to read a pending report
	task automatic wait_low(input logic halt);
		int i;
		for (i = 0; i < 40 && (halt ? level1_irq : level2_irq) !== 1'b0; i++) step();
		if (i == 40) begin
			error_cnt++;
			results();
		end
	endtask : wait_low

	task automatic fire_err(input logic hw, input logic [3:0] cause);
		err_valid = 1'b1;
		err_hardware = hw;
		err_cause = cause;
		err_flag = 1'($urandom);
		err_iface = 1'($urandom);
		step();
		err_valid = 1'b0;
		if (high_speed_mode || hw) restr = 1'b1;
	endtask : fire_err

	task automatic after_ev(input logic [7:0] exp);
		chk("line_comm_status", exp, line_comm_status);
		chk_bit("level2_irq", 1'b1, level2_irq);
		wait_low(1'b0);
		chk("seen_status", exp, seen_status);
	endtask : after_ev

	task automatic cmd(input logic [2:0] c);
		logic ok;
		ok = !restr || (high_speed_mode ? c <= 3'h1 : (c == 3'h1 || c == 3'h2 ||
			(c == 3'h3 && autocall_iface)));
		ok = ok && !(other_line_active && c == 3'h0);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_iface = 1'($urandom);
		step();
		cmd_valid = 1'b0;
		chk_bit("cmd_accept", ok, cmd_accept);
		chk_bit("cmd_reject", !ok, cmd_reject);
		if (c == 3'h1) begin
			restr = 1'b0;
			chk("line_state", 8'h00, {6'h0, line_state});
		end
		step();
	endtask : cmd

	initial begin
		#5ms;
		error_cnt++;
		results();
	end

	initial begin
		{rst_b, high_speed_mode, emulation_mode, duplex_line, autocall_iface, err_valid,
			err_hardware, err_cause, err_flag, err_iface, dma_fault_valid, letter_faults,
			dma_faults, attach_clock_fail, local_attach_busy, cmd_valid, cmd_code, cmd_iface,
			other_line_active, halt_signal, prog_op_active, ext_reg02} = '0;
		{error_cnt, tests_run, restr, read_delay} = '0;
		read_delay = 4'h1;
		void'($urandom(88));
		step(12);
		rst_b = 1'b1;
		step(3);
		chk("line_comm_status", 8'h00, line_comm_status);
		chk("halt_error_record_byte0", 8'h00, halt_error_record_byte0);
		repeat (24) begin
			{high_speed_mode, emulation_mode, duplex_line, autocall_iface} = 4'($urandom);
			fire_err(1'($urandom), 4'($urandom));
			code = {err_hardware ? 3'h7 : 3'h6, err_cause, high_speed_mode ? 1'b0 : err_flag};
			chk("line_state", (emulation_mode && !high_speed_mode) ? 8'h02 : 8'h01,
				{6'h0, line_state});
			if (duplex_line && !emulation_mode) begin
				chk("iface_end", 8'h01 << err_iface, {6'h0, iface_end});
				chk("iface_clear", 8'h02 >> err_iface, {6'h0, iface_clear});
			end
			after_ev(code);
			cmd(3'($urandom_range(4, 0)));
			cmd(lesr_pkg::CMD_ENABLE);
		end
		high_speed_mode = 1'b1;
		foreach (fast_tab[i]) begin
			fire_err(fast_tab[i][5], fast_tab[i][4:1]);
			after_ev(fast_tab[i]);
			cmd(lesr_pkg::CMD_ENABLE);
		end
		for (int i = 0; i < 30; i++) begin
			code = 8'haa;
			letter_faults = 8'($urandom_range(255, 1));
			dma_faults = 6'h20;
			if (i < 24) {letter_faults, dma_faults, code} =
				{ext_tab[i][23:16], ext_tab[i][13:8], ext_tab[i][7:0]};
			dma_fault_valid = 1'b1;
			step();
			dma_fault_valid = 1'b0;
			chk("extended_line_status", code, extended_line_status);
			after_ev(8'hdc);
			chk("seen_ext", code, seen_ext);
			restr = 1'b1;
			cmd(lesr_pkg::CMD_ENABLE);
		end
		other_line_active = 1'b1;
		cmd(lesr_pkg::CMD_SET_MODE);
		other_line_active = 1'b0;
		after_ev(8'hde);
		restr = 1'b1;
		cmd(lesr_pkg::CMD_ENABLE);
		local_attach_busy = 1'b1;
		for (int m = 0; m < 2; m++) begin
			high_speed_mode = m[0];
			attach_clock_fail = 1'b1;
			step();
			attach_clock_fail = 1'b0;
			after_ev(8'hce);
			restr = high_speed_mode;
			cmd(lesr_pkg::CMD_ENABLE);
		end
		// Second event while the first is unread must not replace it
		read_delay = 4'hf;
		fire_err(1'b0, 4'h9);
		step(2);
		fire_err(1'b0, 4'h4);
		chk("line_comm_status", 8'hd2, line_comm_status);
		wait_low(1'b0);
		chk("seen_status", 8'hd2, seen_status);
		step();
		chk_bit("level2_irq", 1'b0, level2_irq);
		cmd(lesr_pkg::CMD_ENABLE);
		read_delay = 4'h3;
		prog_op_active = 1'b1;
		repeat (4) begin
			ext_reg02 = 8'($urandom);
			code = ext_reg02 & 8'hde;
			halt_signal = 1'b1;
			step();
			chk_bit("level1_irq", 1'b1, level1_irq);
			chk("halt_error_record_byte0", code, halt_error_record_byte0);
			ext_reg02 = ~ext_reg02;
			step();
			halt_signal = 1'b0;
			chk("halt_error_record_byte0", code, halt_error_record_byte0);
			wait_low(1'b1);
			chk("seen_halt", code, seen_halt);
		end
		prog_op_active = 1'b0;
		halt_signal = 1'b1;
		step();
		halt_signal = 1'b0;
		chk_bit("level1_irq", 1'b0, level1_irq);
		results();
	end
endmodule : tb

// ### verilog/lesr_extended_line_status.sv
// Purpose: Encodes storage and transfer faults into the extended status
// Assumes: Fault vectors are stable in the cycle they are used
// Notes: Unlisted combinations fall back to the catch-all code
`timescale 1ns/1ps
module lesr_ext_enc (
	lesr_ext_if.encoder bus
);
	function automatic logic [7:0] single_code(input logic [13:0] v);
		case (v)
			14'h0001: single_code = lesr_pkg::EXT_A;
			14'h0002: single_code = lesr_pkg::EXT_B;
			14'h0004: single_code = lesr_pkg::EXT_C;
			14'h0008: single_code = lesr_pkg::EXT_D;
			14'h0010: single_code = lesr_pkg::EXT_E;
			14'h0020: single_code = lesr_pkg::EXT_F;
			14'h0040: single_code = lesr_pkg::EXT_G;
			14'h0080: single_code = lesr_pkg::EXT_H;
			14'h0100: single_code = lesr_pkg::EXT_1;
			14'h0200: single_code = lesr_pkg::EXT_2;
			14'h0400: single_code = lesr_pkg::EXT_3;
			14'h0800: single_code = lesr_pkg::EXT_4;
			14'h1000: single_code = lesr_pkg::EXT_5;
			14'h2000: single_code = lesr_pkg::EXT_6;
			14'h0060: single_code = lesr_pkg::EXT_FG;
			14'h00a0: single_code = lesr_pkg::EXT_FH;
			14'h0030: single_code = lesr_pkg::EXT_EF;
			14'h0070: single_code = lesr_pkg::EXT_EFG;
			14'h0270: single_code = lesr_pkg::EXT_2EFG;
			14'h0170: single_code = lesr_pkg::EXT_1EFG;
			14'h0240: single_code = lesr_pkg::EXT_2G;
			14'h0280: single_code = lesr_pkg::EXT_2H;
			14'h1070: single_code = lesr_pkg::EXT_5EFG;
			default: single_code = lesr_pkg::EXT_OTHER;
		endcase
	endfunction : single_code

	logic [13:0] all_faults;
	assign all_faults = {bus.dma_faults, bus.letter_faults};

	always_comb begin
		if (all_faults == 14'h0000) begin
			bus.ext_code = lesr_pkg::EXT_NONE;
		end else if (bus.dma_faults[lesr_pkg::BURST_BIT] && (bus.letter_faults != 8'h00)) begin
			bus.ext_code = lesr_pkg::EXT_BURST_ANY;
		end else begin
			bus.ext_code = single_code(all_faults);
		end
	end
endmodule : lesr_ext_enc

// ### verilog/lesr_top.sv
// Purpose: Builds line status on errors and the halt error record
// Assumes: All event inputs come from logic on mclk
// Notes: A held status blocks new status capture until it is read
`timescale 1ns/1ps
module lesr_top (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic high_speed_mode,
	input wire logic emulation_mode,
	input wire logic duplex_line,
	input wire logic autocall_iface,
	input wire logic err_valid,
	input wire logic err_hardware,
	input wire logic [3:0] err_cause,
	input wire logic err_flag,
	input wire logic err_iface,
	input wire logic dma_fault_valid,
	input wire logic [7:0] letter_faults,
	input wire logic [5:0] dma_faults,
	input wire logic attach_clock_fail,
	input wire logic local_attach_busy,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic cmd_iface,
	input wire logic other_line_active,
	input wire logic status_read,
	input wire logic halt_signal,
	input wire logic prog_op_active,
	input wire logic [7:0] ext_reg02,
	input wire logic halt_read,
	output logic [7:0] line_comm_status,
	output logic [7:0] extended_line_status,
	output logic level2_irq,
	output logic level1_irq,
	output logic [7:0] halt_error_record_byte0,
	output logic [1:0] line_state,
	output logic [1:0] iface_end,
	output logic [1:0] iface_clear,
	output logic cmd_accept,
	output logic cmd_reject
);
	function automatic logic [7:0] make_status(input logic [2:0] init_f,
		input logic [3:0] final_f, input logic flag);
		make_status = {init_f, final_f, flag};
	endfunction : make_status

	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	lesr_ext_if ext_bus ();
	assign ext_bus.letter_faults = letter_faults;
	assign ext_bus.dma_faults = dma_faults;
	lesr_ext_enc u_ext (
		.bus(ext_bus.encoder)
	);

	logic [7:0] status_reg;
	logic [7:0] ext_reg;
	logic pending_reg;
	logic halt_pending_reg;
	logic [7:0] halt_rec_reg;
	lesr_pkg::lesr_line_t line_reg;
	logic restricted_reg;
	logic [1:0] end_reg;
	logic [1:0] clear_reg;
	logic accept_reg;
	logic reject_reg;

	logic ev_pair;
	logic ev_clk;
	logic ev_dma;
	logic ev_err;
	logic ev_any;
	logic ev_hw;
	logic ev_take;
	logic halt_ev;
	logic ev_iface;
	logic cmd_allowed;
	logic cmd_plain;
	logic [7:0] status_next;

	assign ev_pair = cmd_valid && (cmd_code == lesr_pkg::CMD_SET_MODE) && other_line_active;
	assign ev_clk = attach_clock_fail && local_attach_busy;
	assign ev_dma = dma_fault_valid && high_speed_mode;
	assign ev_err = err_valid && !(ev_pair || ev_clk || ev_dma);
	assign ev_any = ev_pair || ev_clk || ev_dma || err_valid;
	assign ev_hw = ev_err && err_hardware;
	// A read in the same cycle frees the holder, so that event is kept
	assign ev_take = ev_any && (!pending_reg || status_read);
	assign ev_iface = ev_pair ? cmd_iface : err_iface;
	assign halt_ev = halt_signal && prog_op_active;
	assign cmd_plain = cmd_valid && !ev_pair;

	always_comb begin
		if (ev_pair) begin
			status_next = make_status(lesr_pkg::INIT_INTERNAL, lesr_pkg::FINAL_NOT_ACCESSIBLE,
				1'b0);
		end else if (ev_clk) begin
			status_next = make_status(lesr_pkg::INIT_INTERNAL, lesr_pkg::FINAL_CLOCK_FAIL,
				1'b0);
		end else if (ev_dma) begin
			status_next = make_status(lesr_pkg::INIT_INTERNAL, lesr_pkg::FINAL_EXT_VALID,
				1'b0);
		end else if (ev_hw) begin
			// Cause code selects E2, EE, F2..FA when the flag is cleared
			status_next = make_status(lesr_pkg::INIT_HARDWARE, err_cause,
				err_flag && !high_speed_mode);
		end else begin
			status_next = make_status(lesr_pkg::INIT_INTERNAL, err_cause,
				err_flag && !high_speed_mode);
		end
	end

	always_comb begin
		case (cmd_code)
			lesr_pkg::CMD_SET_MODE: cmd_allowed = high_speed_mode;
			lesr_pkg::CMD_ENABLE: cmd_allowed = 1'b1;
			lesr_pkg::CMD_MONITOR_CALL: cmd_allowed = !high_speed_mode;
			lesr_pkg::CMD_DIAL: cmd_allowed = !high_speed_mode && autocall_iface;
			default: cmd_allowed = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= lesr_pkg::STATUS_IDLE;
			ext_reg <= lesr_pkg::EXT_NONE;
		end else if (ev_take) begin
			status_reg <= status_next;
			ext_reg <= ev_dma && !ev_pair && !ev_clk ? ext_bus.ext_code
				: lesr_pkg::EXT_NONE;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pending_reg <= 1'b0;
		end else begin
			pending_reg <= ev_take || (pending_reg && !status_read);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			end_reg <= 2'b00;
			clear_reg <= 2'b00;
		end else begin
			end_reg <= 2'b00;
			clear_reg <= 2'b00;
			if (ev_take) begin
				end_reg[ev_iface] <= 1'b1;
				// Other side is only cleared on duplex lines in network mode
				clear_reg[!ev_iface] <= duplex_line && !emulation_mode;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			line_reg <= lesr_pkg::LINE_ACTIVE;
		end else if (ev_any) begin
			// High speed scanner always disables, even in emulation mode
			line_reg <= (emulation_mode && !high_speed_mode) ? lesr_pkg::LINE_NOOP
				: lesr_pkg::LINE_DISABLED;
		end else if (cmd_plain && (cmd_code == lesr_pkg::CMD_ENABLE)) begin
			line_reg <= lesr_pkg::LINE_ACTIVE;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			restricted_reg <= 1'b0;
		end else if (ev_any && (high_speed_mode || ev_hw)) begin
			restricted_reg <= 1'b1;
		end else if (cmd_plain && (cmd_code == lesr_pkg::CMD_ENABLE)) begin
			restricted_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			accept_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			accept_reg <= cmd_plain && (!restricted_reg || cmd_allowed);
			reject_reg <= ev_pair || (cmd_plain && restricted_reg && !cmd_allowed);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			halt_rec_reg <= 8'h00;
		end else if (halt_ev && (!halt_pending_reg || halt_read)) begin
			halt_rec_reg <= ext_reg02 & lesr_pkg::HALT_MASK;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			halt_pending_reg <= 1'b0;
		end else begin
			halt_pending_reg <= halt_ev || (halt_pending_reg && !halt_read);
		end
	end

	assign line_comm_status = status_reg;
	assign extended_line_status = ext_reg;
	assign level2_irq = pending_reg;
	assign level1_irq = halt_pending_reg;
	assign halt_error_record_byte0 = halt_rec_reg;
	assign line_state = line_reg;
	assign iface_end = end_reg;
	assign iface_clear = clear_reg;
	assign cmd_accept = accept_reg;
	assign cmd_reject = reject_reg;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_err_taken;
		ev_take && !ev_hw;
	endsequence
	sequence s_duplex_err;
		ev_take && duplex_line && !emulation_mode;
	endsequence
	sequence s_halt_seen;
		halt_ev && !halt_pending_reg;
	endsequence

	a_internal_field: assert property (s_err_taken |=>
		line_comm_status[7:5] == lesr_pkg::INIT_INTERNAL && level2_irq)
		else $error("internal error field wrong");
	a_hardware_field: assert property (ev_take && ev_hw |=>
		line_comm_status[7:5] == lesr_pkg::INIT_HARDWARE
		&& line_comm_status[4:1] == $past(err_cause))
		else $error("hardware error field wrong");
	a_line_disable: assert property (ev_any && !emulation_mode |=>
		line_state == lesr_pkg::LINE_DISABLED)
		else $error("line not disabled");
	a_line_noop: assert property (ev_any && emulation_mode && !high_speed_mode |=>
		line_state == lesr_pkg::LINE_NOOP)
		else $error("line not in no-op");
	a_duplex_end: assert property (s_duplex_err |=>
		(iface_end != 2'b00) && (iface_clear == ~iface_end) ##1 iface_end == 2'b00)
		else $error("duplex ending wrong");
	a_status_hold: assert property (level2_irq && !status_read |=>
		$stable(line_comm_status) && level2_irq)
		else $error("status changed before read");
	a_fast_even: assert property (ev_take && high_speed_mode |=> !line_comm_status[0])
		else $error("high speed code not even");
	a_pair_code: assert property (ev_pair && ev_take |=>
		line_comm_status == lesr_pkg::STATUS_NOT_ACCESSIBLE && cmd_reject)
		else $error("pair busy code wrong");
	a_clock_code: assert property (ev_clk && !ev_pair && ev_take |=>
		line_comm_status == lesr_pkg::STATUS_CLOCK_FAIL)
		else $error("attach clock code wrong");
	a_ext_byte: assert property (ev_dma && !ev_pair && !ev_clk && ev_take |=>
		line_comm_status == lesr_pkg::STATUS_EXT_VALID
		&& extended_line_status == $past(ext_bus.ext_code))
		else $error("extended status missing");
	a_ext_burst: assert property (ev_dma && !ev_pair && !ev_clk && ev_take
		&& dma_faults[lesr_pkg::BURST_BIT] && letter_faults != 8'h00 |=>
		extended_line_status == lesr_pkg::EXT_BURST_ANY)
		else $error("burst combination code wrong");
	a_cmd_refuse: assert property (restricted_reg && cmd_plain && !cmd_allowed
		&& !ev_any |=> cmd_reject && !cmd_accept && line_state != lesr_pkg::LINE_ACTIVE)
		else $error("command not refused");
	a_halt_record: assert property (s_halt_seen |=> level1_irq
		&& halt_error_record_byte0 == ($past(ext_reg02) & lesr_pkg::HALT_MASK))
		else $error("halt record wrong");
endmodule : lesr_top
